// >>> dv/asxs_alu_test.sv
// self-checking bench for the alu slice against a core state model
// assumes a 10 MHz clock and the one-cycle answer of the slice
`default_nettype none
module asxs_alu_test import asxs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam asxs_op_t OP_SUB = ASXS_SUBTRACT_WORK_FROM_FILE;
   localparam asxs_op_t OP_XWF = ASXS_XOR_WORK_WITH_FILE;
   localparam asxs_op_t OP_SWP = ASXS_NIBBLE_SWAP_FILE;
   localparam asxs_op_t OP_XLW = ASXS_XOR_LITERAL_INTO_WORK;
   logic              clk_in = 1'b0;
   logic              rstn_in = 1'b0;
   logic              req_valid_in = 1'b0;
   asxs_req_t         req_in = '0;
   asxs_flags_t       flags_in = '0;
   logic              work_we_out;
   logic              file_we_out;
   logic              done_out;
   logic [ADDR_W-1:0] file_addr_out;
   logic [DATA_W-1:0] result_out;
   asxs_flags_t       flags_out;
   int                n_errors = 0;
   int                n_compared = 0;
   always #50 clk_in = ~clk_in;
   asxs_alu dut (.clk_in, .rstn_in, .req_valid_in, .req_in, .flags_in, .work_we_out,
      .file_we_out, .file_addr_out, .result_out, .flags_out, .done_out);
   asxs_core_model core (.clk_in, .work_we_in(work_we_out), .file_we_in(file_we_out),
      .done_in(done_out), .file_addr_in(file_addr_out), .result_in(result_out),
      .flags_in(flags_out));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkf(input asxs_flags_t got, input asxs_flags_t exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one operation: preset model, issue, expect done one cycle later
   task automatic run(input asxs_op_t op, input logic d, input logic [6:0] a,
      input logic [7:0] f, input logic [7:0] w, input logic [7:0] k, input asxs_flags_t fl);
      logic [7:0]  r;
      asxs_flags_t ef;
      core.work_reg = w;
      core.file_reg[a] = f;
      core.status_reg = fl;
      case (op)
         OP_SUB:  r = f - w;
         OP_XWF:  r = f ^ w;
         OP_SWP:  r = {f[3:0], f[7:4]};
         default: r = w ^ k;
      endcase
      ef = '{fl.carry, fl.half_carry_flag, r == 8'h00};
      if (op == OP_SUB)
         ef = '{w <= f, w[3:0] <= f[3:0], r == 8'h00};
      if (op == OP_SWP)
         ef = fl;
      @(posedge clk_in);
      req_valid_in <= 1'h1;
      req_in <= '{op, d, a, f, w, k};
      flags_in <= fl;
      @(posedge clk_in);
      req_valid_in <= 1'h0;
      #1;
      chk8({7'h00, done_out}, 8'h01);
      @(posedge clk_in);
      #1;
      chk8({7'h00, done_out}, 8'h00);
      chk8(result_out, r);
      chk8({1'h0, file_addr_out}, {1'h0, a});
      chk8(core.work_reg, (op == OP_XLW || !d) ? r : w);
      chk8(core.file_reg[a], (op != OP_XLW && d) ? r : f);
      chkf(core.status_reg, ef);
   endtask
   task automatic sub_test();
      run(OP_SUB, 1'b0, 7'h00, 8'h05, 8'h03, 8'h00, 3'h0);
      run(OP_SUB, 1'b1, 7'h7F, 8'h03, 8'h05, 8'h00, 3'h7);
      run(OP_SUB, 1'b1, 7'h40, 8'h5A, 8'h5A, 8'h00, 3'h0);
      run(OP_SUB, 1'b0, 7'h11, 8'h10, 8'h01, 8'h00, 3'h0);
      $display("sub_test done");
   endtask
   task automatic xor_test();
      run(OP_XWF, 1'b1, 7'h7F, 8'hA5, 8'h5A, 8'hFF, 3'h6);
      run(OP_XWF, 1'b0, 7'h01, 8'h3C, 8'h3C, 8'h00, 3'h0);
      $display("xor_test done");
   endtask
   task automatic swap_test();
      run(OP_SWP, 1'b1, 7'h22, 8'h1E, 8'h77, 8'h00, 3'h5);
      run(OP_SWP, 1'b0, 7'h23, 8'h00, 8'h77, 8'h00, 3'h2);
      $display("swap_test done");
   endtask
   // reset after an operation completes: every output clears and stays clear until the next request
   task automatic reset_test();
      run(OP_SWP, 1'h1, 7'h5A, 8'h3C, 8'h00, 8'h00, 3'h7);
      @(posedge clk_in);
      rstn_in <= 1'h0;
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      #1;
      chk8(result_out, 8'h00);
      chk8({1'h0, file_addr_out}, 8'h00);
      chk8({2'h0, flags_out, work_we_out, file_we_out, done_out}, 8'h00);
      $display("reset_test done");
   endtask
   task automatic lit_test();
      run(OP_XLW, 1'b1, 7'h24, 8'h99, 8'hF0, 8'hFF, 3'h3);
      run(OP_XLW, 1'b0, 7'h25, 8'h12, 8'h00, 8'h00, 3'h4);
      $display("lit_test done");
   endtask
   initial
   begin
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      sub_test();
      xor_test();
      swap_test();
      reset_test();
      lit_test();
      wrap_up();
   end
   // the tests need about 60 cycles; 2000 means a hang
   initial
   begin
      #200000;
      n_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire

// >>> dv/asxs_core_model.sv
// partner model: working register, file registers and status of the core
// assumes results land on the edge that shows the done pulse
`default_nettype none
module asxs_core_model
   import asxs_pkg::*;
(
   // clock, and results from the slice
   input  wire logic              clk_in,
   input  wire logic              work_we_in,
   input  wire logic              file_we_in,
   input  wire logic              done_in,
   input  wire logic [ADDR_W-1:0] file_addr_in,
   input  wire logic [DATA_W-1:0] result_in,
   input  wire asxs_flags_t       flags_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] work_reg;
   logic [DATA_W-1:0] file_reg [128];
   asxs_flags_t       status_reg;
   // no reset: the bench presets state before each operation
   always @(posedge clk_in)
   begin
      if (work_we_in)
         work_reg <= result_in;
      if (file_we_in)
         file_reg[file_addr_in] <= result_in;
      if (done_in)
         status_reg <= flags_in;
   end
endmodule
`default_nettype wire

// >>> hdl/asxs_alu.sv
// alu slice executing subtract, xor with file, nibble swap and xor literal
// assumes the decoder supplies operands already read and samples results one cycle later
`default_nettype none
module asxs_alu
   import asxs_pkg::*;
(
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rstn_in,
   // request from decoder
   input  wire logic              req_valid_in,
   input  wire asxs_req_t         req_in,
   // current flags from status register
   input  wire asxs_flags_t       flags_in,
   // results
   output var  logic              work_we_out,
   output var  logic              file_we_out,
   output var  logic [ADDR_W-1:0] file_addr_out,
   output var  logic [DATA_W-1:0] result_out,
   output var  asxs_flags_t       flags_out,
   output var  logic              done_out
);
   // ****************************************
   // next-value logic
   // ****************************************
   logic              work_we_reg, work_we_next;
   logic              file_we_reg, file_we_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] result_reg, result_next;
   asxs_flags_t       flags_reg, flags_next;
   logic              done_reg, done_next;

   always_comb
   begin
      logic [DATA_W-1:0] res;
      res          = ZERO_BYTE;
      // write strobes are one-cycle pulses, low unless a request is taken
      work_we_next = 1'h0;
      file_we_next = 1'h0;
      addr_next    = addr_reg;
      result_next  = result_reg;
      flags_next   = flags_reg;
      done_next    = req_valid_in;
      if (req_valid_in)
      begin
         // flags start from the core's status; each operation overrides only its own
         flags_next = flags_in;
         unique case (req_in.op)
            ASXS_SUBTRACT_WORK_FROM_FILE:
            begin
               res = req_in.file_data - req_in.work_data;
               // carry is a not-borrow: set when work <= file
               flags_next.carry = (req_in.work_data <= req_in.file_data);
               flags_next.half_carry_flag =
                  (req_in.work_data[NIB_W-1:0] <= req_in.file_data[NIB_W-1:0]);
               flags_next.zero = (res == ZERO_BYTE);
            end
            ASXS_XOR_WORK_WITH_FILE:
            begin
               res = req_in.work_data ^ req_in.file_data;
               flags_next.zero = (res == ZERO_BYTE);
            end
            ASXS_NIBBLE_SWAP_FILE:
            begin
               // flags pass through untouched
               res = {req_in.file_data[NIB_W-1:0], req_in.file_data[DATA_W-1:NIB_W]};
            end
            ASXS_XOR_LITERAL_INTO_WORK:
            begin
               res = req_in.work_data ^ req_in.literal;
               flags_next.zero = (res == ZERO_BYTE);
            end
         endcase
         result_next = res;
         addr_next   = req_in.file_addr;
         if (req_in.op == ASXS_XOR_LITERAL_INTO_WORK)
         begin
            work_we_next = 1'h1;
         end
         else
         begin
            work_we_next = ~req_in.dest_file;
            file_we_next = req_in.dest_file;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         work_we_reg <= 1'h0;
         file_we_reg <= 1'h0;
         addr_reg    <= '0;
         result_reg  <= ZERO_BYTE;
         flags_reg   <= FLAGS_RESET;
         done_reg    <= 1'h0;
      end
      else
      begin
         work_we_reg <= work_we_next;
         file_we_reg <= file_we_next;
         addr_reg    <= addr_next;
         result_reg  <= result_next;
         flags_reg   <= flags_next;
         done_reg    <= done_next;
      end
   end

   assign work_we_out   = work_we_reg;
   assign file_we_out   = file_we_reg;
   assign file_addr_out = addr_reg;
   assign result_out    = result_reg;
   assign flags_out     = flags_reg;
   assign done_out      = done_reg;

   // ****************************************
   // assertions
   // ****************************************
   // every property looks one edge after the cycle that it checks, a request or an idle cycle
   a_sub_result: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_SUBTRACT_WORK_FROM_FILE |=>
      result_out == $past(req_in.file_data) - $past(req_in.work_data))
      else $error("subtract result wrong");
   a_dest_select: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op != ASXS_XOR_LITERAL_INTO_WORK |=>
      file_we_out == $past(req_in.dest_file) && work_we_out != file_we_out)
      else $error("destination select wrong");
   a_sub_carry: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_SUBTRACT_WORK_FROM_FILE |=>
      flags_out.carry == ($past(req_in.work_data) <= $past(req_in.file_data)))
      else $error("subtract carry wrong");
   a_xor_flags: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_XOR_WORK_WITH_FILE |=>
      flags_out.carry == $past(flags_in.carry)
      && flags_out.half_carry_flag == $past(flags_in.half_carry_flag))
      else $error("xor touched carry flags");
   a_swap_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_NIBBLE_SWAP_FILE |=>
      result_out[DATA_W-1:NIB_W] == $past(req_in.file_data[NIB_W-1:0])
      && result_out[NIB_W-1:0] == $past(req_in.file_data[DATA_W-1:NIB_W])
      && flags_out == $past(flags_in))
      else $error("swap wrong");
   a_lit_work: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_XOR_LITERAL_INTO_WORK |=>
      work_we_out && !file_we_out
      && result_out == ($past(req_in.work_data) ^ $past(req_in.literal)))
      else $error("literal xor wrong");
   a_zero_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op != ASXS_NIBBLE_SWAP_FILE |=>
      flags_out.zero == (result_out == ZERO_BYTE))
      else $error("zero flag wrong");
   a_idle_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !req_valid_in |=> !work_we_out && !file_we_out && !done_out)
      else $error("write without request");

   // half carry is the same not-borrow test on the low nibbles only
   a_sub_half: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_SUBTRACT_WORK_FROM_FILE |=>
      flags_out.half_carry_flag ==
      ($past(req_in.work_data[NIB_W-1:0]) <= $past(req_in.file_data[NIB_W-1:0])))
      else $error("subtract half carry wrong");

   // a zero difference means equal operands, so both not-borrow bits must be set
   a_sub_equal: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_SUBTRACT_WORK_FROM_FILE |=>
      !flags_out.zero || (flags_out.carry && flags_out.half_carry_flag))
      else $error("subtract zero without carry");

   // a borrow wraps the difference above the file value, no borrow keeps it at or below
   a_sub_wrap: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_SUBTRACT_WORK_FROM_FILE |=>
      flags_out.carry == (result_out <= $past(req_in.file_data)))
      else $error("subtract carry disagrees with difference");

   // zero flag cross-checked against operand equality, not against the result path
   a_sub_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_SUBTRACT_WORK_FROM_FILE |=>
      flags_out.zero == ($past(req_in.work_data) == $past(req_in.file_data)))
      else $error("subtract zero flag wrong");

   a_xor_result: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_XOR_WORK_WITH_FILE |=>
      result_out == ($past(req_in.work_data) ^ $past(req_in.file_data)))
      else $error("xor with file result wrong");

   // an xor is zero exactly when both operands match
   a_xor_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_XOR_WORK_WITH_FILE |=>
      flags_out.zero == ($past(req_in.work_data) == $past(req_in.file_data)))
      else $error("xor with file zero flag wrong");

   a_lit_flags: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && req_in.op == ASXS_XOR_LITERAL_INTO_WORK |=>
      flags_out.carry == $past(flags_in.carry)
      && flags_out.half_carry_flag == $past(flags_in.half_carry_flag)
      && flags_out.zero == ($past(req_in.work_data) == $past(req_in.literal)))
      else $error("literal xor flags wrong");

   // literal xor ignores the destination bit and always lands in the working register
   a_work_dest: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in && (!req_in.dest_file || req_in.op == ASXS_XOR_LITERAL_INTO_WORK) |=>
      work_we_out && !file_we_out)
      else $error("working register destination not taken");

   // the decoder relies on one done pulse per request to retire it
   a_done_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in |=> done_out)
      else $error("request without done");

   a_addr_follow: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_valid_in |=> file_addr_out == $past(req_in.file_addr))
      else $error("write address wrong");

   // result, flags and address hold between requests so a slow register file may take them late
   a_idle_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !req_valid_in |=> $stable(result_out) && $stable(flags_out)
      && $stable(file_addr_out))
      else $error("result moved without request");
endmodule
`default_nettype wire

// >>> hdl/asxs_pkg.sv
// package for the alu slice: operation codes, flag layout, field positions
// assumes the core decoder presents one operation per cycle with a valid strobe
// Operation
// - subtract: file value minus working value, two's complement; file address 0..127
// - destination bit 0 writes working register, 1 writes back to file
// - subtract sets carry and half carry when working not above file (byte, nibble)
// - xor with file: working xor file to destination, only zero flag changes
// - swap: file low nibble to high, high to low; no flag changes
// - xor literal: working xor 8-bit immediate into working, zero flag updated
`default_nettype none
package asxs_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam logic [ADDR_W-1:0] FILE_ADDR_MAX = 7'h7F;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam int NIB_W = 4;

   // ****************************************
   // operation codes
   // ****************************************
   typedef enum logic [1:0] {
      ASXS_SUBTRACT_WORK_FROM_FILE = 2'h0,
      ASXS_XOR_WORK_WITH_FILE      = 2'h1,
      ASXS_NIBBLE_SWAP_FILE        = 2'h2,
      ASXS_XOR_LITERAL_INTO_WORK   = 2'h3
   } asxs_op_t;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      asxs_op_t              op;
      logic                  dest_file;
      logic [ADDR_W-1:0]     file_addr;
      logic [DATA_W-1:0]     file_data;
      logic [DATA_W-1:0]     work_data;
      logic [DATA_W-1:0]     literal;
   } asxs_req_t;

   typedef struct packed {
      logic carry;
      logic half_carry_flag;
      logic zero;
   } asxs_flags_t;

   localparam asxs_flags_t FLAGS_RESET = 3'h0;
endpackage
`default_nettype wire
